// File: verilog/uar_params.svh
// timing and sample-position constants for the receive recovery block
// assumes inclusion by the tick divider and recovery modules only
`ifndef UAR_PARAMS_SVH
`define UAR_PARAMS_SVH
`define UAR_SPB_NORMAL   5'd16
`define UAR_SPB_DOUBLE   5'd8
`define UAR_VOTE_N_FIRST 5'd8
`define UAR_VOTE_N_MID   5'd9
`define UAR_VOTE_N_LAST  5'd10
`define UAR_VOTE_D_FIRST 5'd4
`define UAR_VOTE_D_MID   5'd5
`define UAR_VOTE_D_LAST  5'd6
`define UAR_DBITS_MIN    4'd5
`define UAR_DBITS_MAX    4'd10
`define UAR_DIV_RST      12'h000
`endif

// File: verilog/uar_pkg.sv
// types shared by the receive recovery modules
// assumes uar_params.svh is on the include path
package uar_pkg;
    typedef enum logic [1:0] {
        UAR_IDLE  = 2'b00,
        UAR_START = 2'b01,
        UAR_DATA  = 2'b11,
        UAR_STOP  = 2'b10
    } uar_state_t;
endpackage : uar_pkg

// File: verilog/uar_tick_if.sv
// oversampling tick carrier between divider and recovery core
// assumes a single clock domain
interface uar_tick_if;
    logic tick;
    logic dbl;
    modport gen (output tick, output dbl);
    modport use_ (input tick, input dbl);
endinterface : uar_tick_if

// File: verilog/uar_tick_gen.sv
// oversampling tick divider
// assumes divisor input is static while the receiver is running
`include "uar_params.svh"
module uar_tick_gen
    import uar_pkg::*;
#(
    parameter int DW = 12
) (
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic [DW-1:0] baud_divisor_value,
    input  wire logic          double_speed_select,
    uar_tick_if.gen            tk
);
    logic [DW-1:0] cnt_q;
    logic          tick_q;

    // [RQ20] one tick per divisor period
    // [RQ16] exact divide, error set by divisor
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= DW'(`UAR_DIV_RST);
            tick_q <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q  <= baud_divisor_value;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q - 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign tk.tick = tick_q;
    assign tk.dbl  = double_speed_select;
endmodule : uar_tick_gen

// File: verilog/uar_rx_recovery.sv
// asynchronous receive clock and data recovery core
// assumes the downstream buffer takes frame_valid pulses without stall
`include "uar_params.svh"

// What this block does
// [RQ1] sample at 16x normal, 8x double speed
// [RQ2] double speed select bit chooses mode
// [RQ3] falling edge starts detection, sample one
// [RQ4] start check samples 8-10 or 4-6
// [RQ5] high majority rejects start as noise
// [RQ6] realign bit counter on every valid start
// [RQ7] state counter sixteen or eight per bit
// [RQ8] centre three samples decide every bit
// [RQ9] vote samples 8,9,10 or 4,5,6
// [RQ10] two of three majority sets value
// [RQ11] stop after first stop bit only
// [RQ12] zero stop bit sets stop error
// [RQ13] rearm right after last stop vote
// [RQ14] five to ten data plus parity bits
// [RQ15] transmitter rate within tolerated ratio
// [RQ16] split rate error between both ends
// [RQ17] stop error travels with its frame
// [RQ18] double speed halves the samples per bit
// [RQ19] two flop synchroniser on serial input
// [RQ20] advance only on oversampling ticks
module uar_rx_recovery
    import uar_pkg::*;
#(
    parameter int DW = 12
) (
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic          rx_enable,
    input  wire logic          serial_input_line,
    input  wire logic          double_speed_select,
    input  wire logic [DW-1:0] baud_divisor_value,
    input  wire logic [3:0]    frame_bits,
    output logic [9:0]         frame_data,
    output logic               stop_bit_error_flag,
    output logic               frame_valid,
    output logic               rx_busy
);
    // ****************************************
    // tick source
    // ****************************************
    uar_tick_if tk ();

    // [RQ18] same ticks, eight samples per bit
    uar_tick_gen #(.DW(DW)) u_tick (
        .mclk               (mclk),
        .nrst               (nrst),
        .baud_divisor_value (baud_divisor_value),
        .double_speed_select(double_speed_select),
        .tk                 (tk)
    );

    // ****************************************
    // input synchroniser
    // ****************************************
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // [RQ19] two flops, idle high after reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= serial_input_line;
            sync2_q <= sync1_q;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : maj3

    function automatic logic [3:0] clamp_bits(input logic [3:0] b);
        if (b < `UAR_DBITS_MIN)
            return `UAR_DBITS_MIN;
        else if (b > `UAR_DBITS_MAX)
            return `UAR_DBITS_MAX;
        return b;
    endfunction : clamp_bits

    // ****************************************
    // recovery state
    // ****************************************
    uar_state_t  st_q;
    logic [4:0]  smp_q;
    logic [3:0]  bit_q;
    logic [3:0]  nbits_q;
    logic [2:0]  vote_q;
    logic [9:0]  shf_q;
    logic        mode_q;

    logic [4:0] spb;
    logic [4:0] v_first;
    logic [4:0] v_mid;
    logic [4:0] v_last;
    logic       voted;

    // [RQ1] samples per bit by mode
    // [RQ18] half the samples doubles the rate
    // [RQ2] mode latched at start of frame
    assign spb     = mode_q ? `UAR_SPB_DOUBLE : `UAR_SPB_NORMAL;
    // [RQ9] vote window positions
    assign v_first = mode_q ? `UAR_VOTE_D_FIRST : `UAR_VOTE_N_FIRST;
    assign v_mid   = mode_q ? `UAR_VOTE_D_MID : `UAR_VOTE_N_MID;
    assign v_last  = mode_q ? `UAR_VOTE_D_LAST : `UAR_VOTE_N_LAST;
    // [RQ10] majority of the three centre samples
    assign voted   = maj3({vote_q[2:1], sync2_q});

    // edge detect only on ticks, previous sample of the stable copy
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            prev_q <= 1'b1;
        else if (tk.tick)
            prev_q <= sync2_q;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q    <= UAR_IDLE;
            smp_q   <= 5'h00;
            bit_q   <= 4'h0;
            nbits_q <= `UAR_DBITS_MIN;
            vote_q  <= 3'h0;
            shf_q   <= 10'h000;
            mode_q  <= 1'b0;
        end else if (!rx_enable) begin
            st_q  <= UAR_IDLE;
            smp_q <= 5'h00;
        end else if (tk.tick) begin
            // [RQ20] one state step per tick
            unique case (st_q)
                UAR_IDLE: begin
                    // [RQ3] first low sample is sample one
                    if (prev_q && !sync2_q) begin
                        st_q    <= UAR_START;
                        smp_q   <= 5'h01;
                        mode_q  <= tk.dbl;
                        nbits_q <= clamp_bits(frame_bits);
                    end
                end
                UAR_START: begin
                    smp_q <= smp_q + 5'h01;
                    if (smp_q + 5'h01 == v_first)
                        vote_q[2] <= sync2_q;
                    if (smp_q + 5'h01 == v_mid)
                        vote_q[1] <= sync2_q;
                    // [RQ4] judge start on samples 8-10 / 4-6
                    if (smp_q + 5'h01 == v_last) begin
                        // [RQ5] high majority means noise
                        if (voted)
                            st_q <= UAR_IDLE;
                    end
                    // [RQ6] realign counter to this start bit
                    if (smp_q + 5'h01 == spb) begin
                        st_q  <= UAR_DATA;
                        smp_q <= 5'h00;
                        bit_q <= 4'h0;
                    end
                end
                UAR_DATA: begin
                    // [RQ7] state counter numbers each sample
                    smp_q <= (smp_q + 5'h01 == spb) ? 5'h00 : smp_q + 5'h01;
                    if (smp_q + 5'h01 == v_first)
                        vote_q[2] <= sync2_q;
                    if (smp_q + 5'h01 == v_mid)
                        vote_q[1] <= sync2_q;
                    // [RQ8] same vote for data and parity
                    if (smp_q + 5'h01 == v_last)
                        shf_q[bit_q] <= voted;
                    if (smp_q + 5'h01 == spb) begin
                        bit_q <= bit_q + 4'h1;
                        // [RQ14] frame length from setting
                        if (bit_q + 4'h1 == nbits_q)
                            st_q <= UAR_STOP;
                    end
                end
                UAR_STOP: begin
                    smp_q <= smp_q + 5'h01;
                    if (smp_q + 5'h01 == v_first)
                        vote_q[2] <= sync2_q;
                    if (smp_q + 5'h01 == v_mid)
                        vote_q[1] <= sync2_q;
                    // [RQ11] first stop bit ends the frame
                    // [RQ13] rearm at last stop vote sample
                    if (smp_q + 5'h01 == v_last) begin
                        st_q  <= UAR_IDLE;
                        smp_q <= 5'h00;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // frame hand-off
    // ****************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            frame_data          <= 10'h000;
            stop_bit_error_flag <= 1'b0;
            frame_valid         <= 1'b0;
        end else begin
            frame_valid <= 1'b0;
            if (rx_enable && tk.tick && st_q == UAR_STOP && smp_q + 5'h01 == v_last) begin
                frame_valid         <= 1'b1;
                // unused high bits forced to zero for short characters
                for (int i = 0; i < 10; i++)
                    frame_data[i] <= (4'(i) < nbits_q) ? shf_q[i] : 1'b0;
                // [RQ12] zero stop bit flags error
                // [RQ17] flag paired with its frame data
                stop_bit_error_flag <= ~voted;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            rx_busy <= 1'b0;
        else
            rx_busy <= (st_q != UAR_IDLE);
    end
endmodule : uar_rx_recovery

// File: verif/uar_rx_checker.sv
// assertions on the recovery core ports
// assumes binding into uar_rx_recovery, one clock
module uar_rx_checker #(
    parameter int DW = 12
) (
    input wire logic          mclk,
    input wire logic          nrst,
    input wire logic          rx_enable,
    input wire logic          double_speed_select,
    input wire logic [DW-1:0] baud_divisor_value,
    input wire logic [3:0]    frame_bits,
    input wire logic [9:0]    frame_data,
    input wire logic          stop_bit_error_flag,
    input wire logic          frame_valid,
    input wire logic          rx_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] bcnt_q;
    logic [3:0]  nb;
    logic [31:0] unit;
    assign nb = (frame_bits < 4'h5) ? 4'h5 : ((frame_bits > 4'ha) ? 4'ha : frame_bits);
    // loose bounds, tick phase at the start edge floats
    assign unit = (double_speed_select ? 32'h8 : 32'h10) * (32'(baud_divisor_value) + 32'h1);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bcnt_q <= 16'h0;
        end else begin
            bcnt_q <= rx_busy ? bcnt_q + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_pulse; frame_valid |=> !frame_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("valid too long");
    property p_dhold; $changed(frame_data) |-> frame_valid; endproperty
    a_dhold: assert property (p_dhold) else $error("data moved");
    property p_fhold; $changed(stop_bit_error_flag) |-> frame_valid; endproperty
    a_fhold: assert property (p_fhold) else $error("flag moved");
    property p_upper; frame_valid |-> (frame_data >> nb) == 10'h0; endproperty
    a_upper: assert property (p_upper) else $error("extra bits");
    property p_busy; frame_valid |-> $past(rx_busy); endproperty
    a_busy: assert property (p_busy) else $error("frame while idle");
    property p_lmin; frame_valid |-> 32'(bcnt_q) >= unit * (32'(nb) + 32'h1); endproperty
    a_lmin: assert property (p_lmin) else $error("frame too short");
    property p_lmax; frame_valid |-> 32'(bcnt_q) <= unit * (32'(nb) + 32'h2); endproperty
    a_lmax: assert property (p_lmax) else $error("frame too long");
    property p_off; !rx_enable [*2] |=> !rx_busy && !frame_valid; endproperty
    a_off: assert property (p_off) else $error("active while off");
endmodule : uar_rx_checker
bind uar_rx_recovery uar_rx_checker #(.DW(DW)) chk_u (
    .mclk(mclk), .nrst(nrst), .rx_enable(rx_enable),
    .double_speed_select(double_speed_select), .baud_divisor_value(baud_divisor_value),
    .frame_bits(frame_bits), .frame_data(frame_data),
    .stop_bit_error_flag(stop_bit_error_flag), .frame_valid(frame_valid), .rx_busy(rx_busy)
);

// File: verif/uar_tx_model.sv
// far end transmitter model on the serial line
// assumes the caller gives bit and stop lengths in mclk cycles
module uar_tx_model (
    input wire logic mclk,
    output logic     line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line = 1'b1;
    task automatic send(input logic [9:0] d, input int n, input logic stop, input int blen,
                        input int slen);
        for (int i = 0; i < n + 2; i++) begin
            @(posedge mclk);
            line <= (i == 0) ? 1'b0 : ((i > n) ? stop : d[i-1]);
            repeat (((i > n) ? slen : blen) - 1) @(posedge mclk);
        end
        @(posedge mclk);
        line <= 1'b1;
    endtask : send
    // low pulse, noise or a bare start
    task automatic spike(input int len);
        @(posedge mclk);
        line <= 1'b0;
        repeat (len) @(posedge mclk);
        line <= 1'b1;
    endtask : spike
endmodule : uar_tx_model

// File: verif/tb_top.sv
// self-checking bench for the receive recovery core
// assumes uar_tx_model on the line, divisor one except in one scenario
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 1;
    logic       mclk       = 1'b0;
    logic       nrst       = 1'b0;
    logic       rx_enable  = 1'b0;
    logic       dbl        = 1'b0;
    logic [3:0] frame_bits = 4'h8;
    logic [11:0] div       = 12'(DIV);
    logic       line;
    logic [9:0] frame_data;
    logic       err_flag;
    logic       frame_valid;
    logic       rx_busy;
    logic [9:0] got_data;
    logic       got_err;
    int         frames      = 0;
    int         miscompares = 0;
    int         comparisons = 0;
    uar_tx_model tx_u (.mclk(mclk), .line(line));
    uar_rx_recovery #(.DW(12)) dut_u (
        .mclk(mclk), .nrst(nrst), .rx_enable(rx_enable), .serial_input_line(line),
        .double_speed_select(dbl), .baud_divisor_value(div), .frame_bits(frame_bits),
        .frame_data(frame_data), .stop_bit_error_flag(err_flag), .frame_valid(frame_valid),
        .rx_busy(rx_busy)
    );
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (frame_valid === 1'b1) begin
            frames   <= frames + 1;
            got_data <= frame_data;
            got_err  <= err_flag;
        end
    end
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic rx_frame(input logic [9:0] d, input int n, input logic stop, input logic dm);
        int f0;
        int blen;
        @(posedge mclk);
        f0 = frames;
        blen = (dm ? 8 : 16) * (int'(div) + 1);
        dbl <= dm;
        frame_bits <= 4'(n);
        tx_u.send(d, n, stop, blen, blen);
        repeat (2) @(posedge mclk);
        chk(10'(frames - f0), 10'h1);
        chk(got_data, d & ~(10'h3ff << n));
        chk({9'h0, got_err}, {9'h0, ~stop});
    endtask : rx_frame
    // back to back, even sizes end in a bad stop bit
    task automatic t_sizes();
        for (int n = 5; n <= 10; n++) begin
            rx_frame(10'h2b5 ^ 10'(n), n, n[0], 1'b0);
        end
    endtask : t_sizes
    task automatic t_double();
        for (int n = 5; n <= 10; n++) begin
            rx_frame(10'h35a, n, 1'b1, 1'b1);
        end
    endtask : t_double
    // start pulse one sample short of valid, then just valid
    task automatic t_noise();
        int f0;
        for (int m = 0; m < 2; m++) begin
            @(posedge mclk);
            dbl <= m[0];
            frame_bits <= 4'h8;
            f0 = frames;
            tx_u.spike(m ? 8 : 16);
            repeat (400) @(posedge mclk);
            chk(10'(frames - f0), 10'h0);
            tx_u.spike(m ? 10 : 18);
            repeat (400) @(posedge mclk);
            chk(10'(frames - f0), 10'h1);
            chk(got_data, 10'h0ff);
        end
    endtask : t_noise
    task automatic t_abort();
        int f0;
        f0 = frames;
        fork
            tx_u.send(10'h0f0, 8, 1'b1, 32, 32);
            begin
                repeat (100) @(posedge mclk);
                rx_enable <= 1'b0;
            end
        join
        @(posedge mclk);
        rx_enable <= 1'b1;
        chk(10'(frames - f0), 10'h0);
        rx_frame(10'h0c3, 8, 1'b1, 1'b0);
    endtask : t_abort
    // slower ticks, both modes
    task automatic t_divisor();
        @(posedge mclk);
        div <= 12'h002;
        rx_frame(10'h1c6, 8, 1'b0, 1'b0);
        rx_frame(10'h239, 10, 1'b1, 1'b1);
        @(posedge mclk);
        div <= 12'(DIV);
    endtask : t_divisor
    // short first stop bit, next start right after its votes
    task automatic t_early();
        int f0;
        @(posedge mclk);
        dbl <= 1'b0;
        frame_bits <= 4'hf;
        f0 = frames;
        tx_u.send(10'h15a, 10, 1'b1, 32, 22);
        tx_u.send(10'h2a5, 10, 1'b1, 32, 32);
        repeat (2) @(posedge mclk);
        chk(10'(frames - f0), 10'h2);
        chk(got_data, 10'h2a5);
        chk({9'h0, got_err}, 10'h0);
    endtask : t_early
    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        rx_enable <= 1'b1;
        repeat (4) @(posedge mclk);
        t_sizes();
        t_abort();
        t_double();
        t_divisor();
        t_early();
        t_noise();
        test_done();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        test_done();
    end
endmodule : tb_top
